// >>> rtl/spic_core.v
// How it works
// - Operating mode 0x3 selects host, 0x2 selects client.
// - Host makes the serial clock from the 8-bit baud divider.
// - Client shifts on edges of the clock the external host supplies.
// - Protected control writes are dropped while enabled or enabling.
// - Protected writes made while disabling are applied once disabling ends.
// - Enable bit one enables the unit, zero disables it.
// - Soft reset returns every register to its reset value.
// - Sync busy bit 0 stays high until soft reset sync completes.
// - Data writes fill transmit holding; data reads pop receive holding.
// - Characters are 8 or 9 bits; transactions hold one or more.
// - One-level transmit buffer and two-level receive buffer.
// - Polarity and phase pick which clock edge samples and which sets up.
// - Outgoing bits change on one edge, incoming bits latch on the other.
// - Bit order selects LSB-first or MSB-first shifting.
// - Select low begins a transaction, high ends it.
// - Host to client on MOSI, client to host on MISO.
// - Every character shifted out brings one character back.
// - Host drives select itself when hardware select is set.
// - Client can match the first character against an 8-bit address.
// - Client keeps working in sleep and flags select transitions.
// - Single-direction operation releases the unused data pad.
// - Client leaves MISO released while select is high.
// - Transmit-empty rises when holding data moves to the shifter.
// - Last bit moves the character into the receive buffer that cycle.
`timescale 1ns/1ps
`include "spic_defines.vh"

module spic_core (
	// Clock and reset
	input  wire        core_clk,
	input  wire        arst_n,
	// Control writes, one-cycle strobes with data
	input  wire        ctrlAWrite,
	input  wire [31:0] ctrlAData,
	input  wire        ctrlBWrite,
	input  wire [31:0] ctrlBData,
	input  wire        baudWrite,
	input  wire [7:0]  baudData,
	input  wire        addrWrite,
	input  wire [7:0]  addrData,
	input  wire        dataWrite,
	input  wire [8:0]  dataIn,
	input  wire        dataRead,
	input  wire        txcClear,
	input  wire        ovfClear,
	// Readback and status
	output reg  [31:0] control_a_register,
	output reg  [31:0] control_b_register,
	output reg  [7:0]  baud,
	output reg  [7:0]  matchAddr,
	output wire [2:0]  sync_busy_register,
	output reg  [8:0]  receive_holding_register,
	output wire        txEmptyFlag,
	output reg         txCompleteFlag,
	output wire        rxCompleteFlag,
	output reg         bufferOverflow,
	output reg         wakeRequest,
	// Serial pins, enables active low
	input  wire        sckIn,
	output wire        sckOut,
	output wire        sckOeN,
	input  wire        mosiIn,
	output wire        mosiOut,
	output wire        mosiOeN,
	input  wire        misoIn,
	output wire        misoOut,
	output wire        misoOeN,
	input  wire        ssIn,
	output reg         ssOut,
	output wire        ssOeN
);

	function [3:0] bitIdx;
		input [3:0] cnt;
		input       lsb;
		input       nine;
		begin
			if (lsb)
				bitIdx = cnt;
			else
				bitIdx = (nine ? `SPIC_LAST_BIT9 : `SPIC_LAST_BIT8) - cnt;
		end
	endfunction

	reg  [1:0]  rstPipe;
	wire        rstSync = rstPipe[1];

	reg         enBusy, enTarget, swBusy, bBusy;
	reg  [1:0]  syncCnt;
	reg         pendA, pendB, pendBaud, pendAddr;
	reg  [31:0] pendAData, pendBData;
	reg  [7:0]  pendBaudData, pendAddrData;

	reg         active, moreChar, pendBit, havePend;
	reg  [3:0]  bitCnt;
	reg  [8:0]  txShift, rxShift, holdData;
	reg         holdValid;
	reg  [7:0]  baudCnt;
	reg         sckLevel;
	reg  [4:0]  halfCnt;
	reg         ssPrev, sckPrev, addrPhase, ignoreXfer;
	reg  [8:0]  rxMem [0:1];
	reg         rxWr, rxRd;
	reg  [1:0]  rxCount;

	wire        enabled  = control_a_register[`SPIC_A_ENABLE];
	wire [2:0]  mode     = control_a_register[`SPIC_A_MODE_HI:`SPIC_A_MODE_LO];
	wire        clock_polarity_bit     = control_a_register[`SPIC_A_CLOCK_POLARITY_BIT];
	wire        clock_phase_bit     = control_a_register[`SPIC_A_CLOCK_PHASE_BIT];
	wire        lsbFirst = control_a_register[`SPIC_A_BIT_ORDER_BIT];
	wire [3:0]  frame_format_field     = control_a_register[`SPIC_A_FRAME_FORMAT_FIELD_HI:`SPIC_A_FRAME_FORMAT_FIELD_LO];
	wire [1:0]  data_out_pad_select     = control_a_register[`SPIC_A_DATA_OUT_PAD_SELECT_HI:`SPIC_A_DATA_OUT_PAD_SELECT_LO];
	wire        nine     = control_b_register[`SPIC_B_CHARACTER_SIZE_FIELD_HI:`SPIC_B_CHARACTER_SIZE_FIELD_LO]
	                       == `SPIC_CHARACTER_SIZE_FIELD_9;
	wire        receiver_enable_bit     = control_b_register[`SPIC_B_RECEIVER_ENABLE_BIT];
	wire        hwSel    = control_b_register[`SPIC_B_HW_SELECT_CONTROL_ENABLE];
	wire        isHost   = enabled && mode == `SPIC_MODE_HOST;
	wire        isClient = enabled && mode == `SPIC_MODE_CLIENT;
	wire        protect  = enabled || (enBusy && enTarget);
	wire        disabling = enBusy && !enTarget;
	wire        syncDone = (enBusy || swBusy || bBusy) && syncCnt == 2'h1;

	// Host clock: one half period is baud plus one core cycles.
	wire        hostEdge = active && baudCnt == baud;
	wire        hostLead = hostEdge && sckLevel == clock_polarity_bit;
	// Client clock: the external clock is sampled and edge detected.
	wire        selected = isClient && !ssIn;
	wire        sckRise  = sckIn && !sckPrev;
	wire        sckFall  = !sckIn && sckPrev;
	wire        cliEdge  = selected && (sckRise || sckFall);
	wire        cliLead  = selected && (clock_polarity_bit ? sckFall : sckRise);
	wire        anyEdge  = isHost ? hostEdge : cliEdge;
	wire        leadEdge = isHost ? hostLead : cliLead;
	wire        sampleEv = anyEdge && (leadEdge != clock_phase_bit);
	wire        setupEv  = anyEdge && (leadEdge == clock_phase_bit);
	wire        inBit    = isHost ? misoIn : mosiIn;
	wire [3:0]  idx      = bitIdx(bitCnt, lsbFirst, nine);
	wire        lastBit  = bitCnt == (nine ? `SPIC_LAST_BIT9 : `SPIC_LAST_BIT8);
	wire        doneEv   = sampleEv && lastBit;
	wire [4:0]  lastHalf = nine ? `SPIC_LAST_HALF9 : `SPIC_LAST_HALF8;

	reg  [8:0]  word;
	always @* begin
		word = rxShift;
		word[idx] = inBit;
		if (!nine)
			word[8] = 1'b0;
	end

	wire        addrMatch = word[7:0] == matchAddr;
	wire        push = doneEv && (addrPhase ? addrMatch
	                   : (receiver_enable_bit && !ignoreXfer));
	wire        pop  = dataRead && rxCount != 2'h0;
	wire        full = rxCount == 2'h2;

	assign sync_busy_register       = {bBusy, enBusy, swBusy};
	assign txEmptyFlag    = !holdValid;
	assign rxCompleteFlag = rxCount != 2'h0;
	// Data pins come straight off the shift register so that a divider of
	// zero still gives a full half period of setup.
	assign sckOut  = sckLevel;
	assign sckOeN  = !isHost;
	assign mosiOut = txShift[idx];
	assign mosiOeN = !(isHost && data_out_pad_select != `SPIC_DATA_OUT_PAD_SELECT_NONE);
	assign misoOut = txShift[idx];
	assign misoOeN = !(selected && !addrPhase && !ignoreXfer
	                 && data_out_pad_select != `SPIC_DATA_OUT_PAD_SELECT_NONE);
	assign ssOeN   = !(isHost && hwSel);

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			rstPipe <= 2'b00;
		else
			rstPipe <= {rstPipe[0], 1'b1};
	end

	// The receive buffer carries data only and needs no reset.
	always @(posedge core_clk) begin
		if (push && !full)
			rxMem[rxWr] <= word;
	end

	task clearAll;
		begin
			control_a_register <= `SPIC_CONTROL_A_REGISTER_RST;
			control_b_register <= `SPIC_CONTROL_B_REGISTER_RST;
			baud <= `SPIC_BAUD_RST;
			matchAddr <= `SPIC_ADDR_RST;
			enBusy <= 1'b0;
			enTarget <= 1'b0;
			swBusy <= 1'b0;
			bBusy <= 1'b0;
			syncCnt <= 2'h0;
			pendA <= 1'b0;
			pendB <= 1'b0;
			pendBaud <= 1'b0;
			pendAddr <= 1'b0;
			pendAData <= `SPIC_CONTROL_A_REGISTER_RST;
			pendBData <= `SPIC_CONTROL_B_REGISTER_RST;
			pendBaudData <= `SPIC_BAUD_RST;
			pendAddrData <= `SPIC_ADDR_RST;
			active <= 1'b0;
			moreChar <= 1'b0;
			pendBit <= 1'b0;
			havePend <= 1'b0;
			bitCnt <= 4'h0;
			txShift <= `SPIC_DATA_RST;
			rxShift <= `SPIC_DATA_RST;
			holdData <= `SPIC_DATA_RST;
			holdValid <= 1'b0;
			baudCnt <= 8'h00;
			sckLevel <= 1'b0;
			halfCnt <= 5'h00;
			ssPrev <= 1'b1;
			sckPrev <= 1'b0;
			addrPhase <= 1'b0;
			ignoreXfer <= 1'b0;
			rxWr <= 1'b0;
			rxRd <= 1'b0;
			rxCount <= 2'h0;
			receive_holding_register <= `SPIC_DATA_RST;
			txCompleteFlag <= 1'b0;
			bufferOverflow <= 1'b0;
			wakeRequest <= 1'b0;
			ssOut <= 1'b1;
		end
	endtask

	always @(posedge core_clk or negedge rstSync) begin
		if (!rstSync) begin
			clearAll;
		end else if (syncDone && swBusy) begin
			clearAll;
		end else begin
			// Register synchronization.
			if (syncCnt != 2'h0)
				syncCnt <= syncCnt - 2'h1;
			if (syncDone) begin
				bBusy <= 1'b0;
				enBusy <= 1'b0;
				if (enBusy && !enTarget) begin
					if (pendA)
						control_a_register <= pendAData & ~`SPIC_A_FREE_MASK;
					if (pendB)
						control_b_register <= pendBData;
					if (pendBaud)
						baud <= pendBaudData;
					if (pendAddr)
						matchAddr <= pendAddrData;
					pendA <= 1'b0;
					pendB <= 1'b0;
					pendBaud <= 1'b0;
					pendAddr <= 1'b0;
				end
				if (enBusy)
					control_a_register[`SPIC_A_ENABLE] <= enTarget;
			end
			if (ctrlAWrite) begin
				if (ctrlAData[`SPIC_A_SOFT_RESET_BIT]) begin
					swBusy <= 1'b1;
					syncCnt <= `SPIC_SYNC_CYCLES;
				end else begin
					if (ctrlAData[`SPIC_A_ENABLE] != (enBusy ? enTarget
					    : enabled)) begin
						enBusy <= 1'b1;
						enTarget <= ctrlAData[`SPIC_A_ENABLE];
						syncCnt <= `SPIC_SYNC_CYCLES;
					end
					if (disabling) begin
						pendA <= 1'b1;
						pendAData <= ctrlAData;
					end else if (!protect)
						control_a_register <= (ctrlAData & ~`SPIC_A_FREE_MASK)
						       | (control_a_register & `SPIC_A_FREE_MASK);
				end
			end
			if (ctrlBWrite) begin
				if (disabling) begin
					pendB <= 1'b1;
					pendBData <= ctrlBData;
				end else if (protect) begin
					control_b_register[`SPIC_B_RECEIVER_ENABLE_BIT] <= ctrlBData[`SPIC_B_RECEIVER_ENABLE_BIT];
					bBusy <= 1'b1;
					syncCnt <= `SPIC_SYNC_CYCLES;
				end else
					control_b_register <= ctrlBData;
			end
			if (baudWrite) begin
				if (disabling) begin
					pendBaud <= 1'b1;
					pendBaudData <= baudData;
				end else if (!protect)
					baud <= baudData;
			end
			if (addrWrite) begin
				if (disabling) begin
					pendAddr <= 1'b1;
					pendAddrData <= addrData;
				end else if (!protect)
					matchAddr <= addrData;
			end

			// Transmit holding; a software write loads it even while it is still full.
			if (dataWrite) begin
				holdData <= nine ? dataIn : {1'b0, dataIn[7:0]};
				holdValid <= 1'b1;
				txCompleteFlag <= 1'b0;
			end
			if (txcClear)
				txCompleteFlag <= 1'b0;

			// Bit engine, shared by host and client.
			if (doneEv) begin
				havePend <= 1'b0;
				moreChar <= 1'b1;
				if (addrPhase) begin
					addrPhase <= 1'b0;
					ignoreXfer <= !addrMatch;
				end
			end else if (sampleEv) begin
				pendBit <= inBit;
				havePend <= 1'b1;
			end else if (setupEv && moreChar) begin
				// The next character waits for a setup edge, so the line
				// never moves on the edge that the far side samples.
				bitCnt <= 4'h0;
				moreChar <= 1'b0;
				if (holdValid) begin
					txShift <= holdData;
					holdValid <= 1'b0;
				end
			end else if (setupEv && havePend) begin
				rxShift[idx] <= pendBit;
				bitCnt <= bitCnt + 4'h1;
				havePend <= 1'b0;
			end

			// Host clock generation and hardware select.
			if (!active) begin
				sckLevel <= clock_polarity_bit;
				if (isHost && holdValid) begin
					active <= 1'b1;
					txShift <= holdData;
					holdValid <= 1'b0;
					baudCnt <= 8'h00;
					halfCnt <= 5'h00;
					bitCnt <= 4'h0;
					havePend <= 1'b0;
					moreChar <= 1'b0;
					if (hwSel)
						ssOut <= 1'b0;
				end
			end else if (!isHost) begin
				active <= 1'b0;
				ssOut <= 1'b1;
			end else if (hostEdge) begin
				baudCnt <= 8'h00;
				sckLevel <= !sckLevel;
				if (halfCnt == lastHalf) begin
					halfCnt <= 5'h00;
					if (!holdValid) begin
						active <= 1'b0;
						txCompleteFlag <= 1'b1;
						ssOut <= 1'b1;
					end
				end else
					halfCnt <= halfCnt + 5'h01;
			end else
				baudCnt <= baudCnt + 8'h01;

			// Client select tracking; edges double as the wake request.
			ssPrev <= ssIn;
			sckPrev <= sckIn;
			wakeRequest <= isClient && ssIn != ssPrev;
			if (isClient && ssIn && !ssPrev) begin
				txCompleteFlag <= 1'b1;
				bitCnt <= 4'h0;
				havePend <= 1'b0;
				moreChar <= 1'b0;
				addrPhase <= 1'b0;
				ignoreXfer <= 1'b0;
			end
			if (isClient && !ssIn && ssPrev)
				addrPhase <= frame_format_field == `SPIC_FRAME_FORMAT_FIELD_ADDR;

			// Two-level receive buffer; a full buffer drops the newcomer.
			if (pop) begin
				receive_holding_register <= rxMem[rxRd];
				rxRd <= !rxRd;
			end
			if (push && !full)
				rxWr <= !rxWr;
			rxCount <= rxCount + {1'b0, push && !full} - {1'b0, pop};
			if (ovfClear)
				bufferOverflow <= 1'b0;
			if (push && full)
				bufferOverflow <= 1'b1;
			if (!receiver_enable_bit) begin
				rxCount <= 2'h0;
				rxWr <= 1'b0;
				rxRd <= 1'b0;
				bufferOverflow <= 1'b0;
			end
		end
	end

endmodule // spic_core

// >>> rtl/spic_defines.vh
`ifndef SPIC_DEFINES_VH
`define SPIC_DEFINES_VH

// Control A field positions.
`define SPIC_A_SOFT_RESET_BIT       0
`define SPIC_A_ENABLE      1
`define SPIC_A_MODE_LO     2
`define SPIC_A_MODE_HI     4
`define SPIC_A_DATA_OUT_PAD_SELECT_LO     16
`define SPIC_A_DATA_OUT_PAD_SELECT_HI     17
`define SPIC_A_DATA_IN_PAD_SELECT_LO     20
`define SPIC_A_DATA_IN_PAD_SELECT_HI     21
`define SPIC_A_FRAME_FORMAT_FIELD_LO     24
`define SPIC_A_FRAME_FORMAT_FIELD_HI     27
`define SPIC_A_CLOCK_PHASE_BIT        28
`define SPIC_A_CLOCK_POLARITY_BIT        29
`define SPIC_A_BIT_ORDER_BIT        30
// Bits of control A that are never enable-protected.
`define SPIC_A_FREE_MASK   32'h00000003

// Control B field positions.
`define SPIC_B_CHARACTER_SIZE_FIELD_LO   0
`define SPIC_B_CHARACTER_SIZE_FIELD_HI   2
`define SPIC_B_HW_SELECT_CONTROL_ENABLE       13
`define SPIC_B_RECEIVER_ENABLE_BIT        17

// Sync busy bit positions.
`define SPIC_SB_SOFT_RESET_BIT      0
`define SPIC_SB_ENABLE     1
`define SPIC_SB_CONTROL_B_REGISTER      2

// Encodings.
`define SPIC_MODE_CLIENT   3'h2
`define SPIC_MODE_HOST     3'h3
`define SPIC_FRAME_FORMAT_FIELD_ADDR     4'h2
`define SPIC_CHARACTER_SIZE_FIELD_9      3'h1
`define SPIC_DATA_OUT_PAD_SELECT_NONE     2'h3

// Reset values.
`define SPIC_CONTROL_A_REGISTER_RST     32'h00000000
`define SPIC_CONTROL_B_REGISTER_RST     32'h00000000
`define SPIC_BAUD_RST      8'h00
`define SPIC_ADDR_RST      8'h00
`define SPIC_DATA_RST      9'h000

// Character geometry.
`define SPIC_LAST_BIT8     4'h7
`define SPIC_LAST_BIT9     4'h8
`define SPIC_LAST_HALF8    5'h0F
`define SPIC_LAST_HALF9    5'h11

// Cycles taken by a register synchronization.
`define SPIC_SYNC_CYCLES   2'h3

`endif

// >>> verification/spic_core_props.sv
`timescale 1ns/1ps
`include "spic_defines.vh"
module spic_core_props (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        arst_n,
	// Requests
	input wire logic        ctrlAWrite,
	input wire logic [31:0] ctrlAData,
	input wire logic        baudWrite,
	input wire logic        dataWrite,
	input wire logic        dataRead,
	// Registers and flags
	input wire logic [31:0] control_a_register,
	input wire logic [31:0] control_b_register,
	input wire logic [7:0]  baud,
	input wire logic [2:0]  sync_busy_register,
	input wire logic [8:0]  receive_holding_register,
	input wire logic        txEmptyFlag,
	input wire logic        rxCompleteFlag,
	// Pins
	input wire logic        sckOut,
	input wire logic        sckOeN,
	input wire logic        mosiOeN,
	input wire logic        misoOeN,
	input wire logic        ssIn,
	input wire logic        ssOut,
	input wire logic        ssOeN
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	wire [2:0] mode = control_a_register[`SPIC_A_MODE_HI:`SPIC_A_MODE_LO];

	host_clock_a: assert property (!sckOeN |-> mode == `SPIC_MODE_HOST)
		else $error("serial clock driven outside host mode");
	clock_rate_a: assert property ($changed(sckOut) && !sckOeN &&
		baud == 8'h03 |=> $stable(sckOut)[*3])
		else $error("serial clock half period wrong");
	data_out_a: assert property (!mosiOeN |-> mode == `SPIC_MODE_HOST &&
		control_a_register[`SPIC_A_DATA_OUT_PAD_SELECT_HI:`SPIC_A_DATA_OUT_PAD_SELECT_LO] != `SPIC_DATA_OUT_PAD_SELECT_NONE)
		else $error("data out driven when it must be released");
	hw_select_a: assert property (!ssOeN |-> control_b_register[`SPIC_B_HW_SELECT_CONTROL_ENABLE])
		else $error("select driven without hardware select");
	miso_release_a: assert property (ssIn[*3] |-> misoOeN)
		else $error("client data driven while deselected");
	select_start_a: assert property ($fell(ssOut) |-> control_a_register[1])
		else $error("select lowered by a disabled unit");
	enable_sync_a: assert property (ctrlAWrite && ctrlAData[1:0] == 2'h2 &&
		!control_a_register[1] && sync_busy_register == 3'h0 |=> sync_busy_register[1] ##[1:4] control_a_register[1])
		else $error("enable did not take effect");
	soft_reset_a: assert property (ctrlAWrite && ctrlAData[0] |=>
		sync_busy_register[0] ##[1:5] (control_a_register == 32'h0 && !sync_busy_register[0]))
		else $error("soft reset did not complete");
	protect_a: assert property (control_a_register[1] && sync_busy_register == 3'h0 && baudWrite
		|=> $stable(baud))
		else $error("protected divider changed while enabled");
	tx_empty_a: assert property (dataWrite |=> !txEmptyFlag)
		else $error("transmit empty stayed high after a load");
	empty_pop_a: assert property (dataRead && !rxCompleteFlag |=>
		$stable(receive_holding_register))
		else $error("read of an empty buffer changed data");
	ninth_bit_a: assert property (dataRead &&
		control_b_register[2:0] != `SPIC_CHARACTER_SIZE_FIELD_9 |=> !receive_holding_register[8])
		else $error("ninth bit nonzero in 8-bit mode");

	cover property ($fell(ssOut));
	cover property (dataRead && rxCompleteFlag);
	cover property (ctrlAWrite && ctrlAData[0]);
endmodule // spic_core_props

bind spic_core spic_core_props chk_u (.*);

// >>> verification/spic_client_model.sv
`timescale 1ns/1ps
module spic_client_model (
	// Serial side
	input  wire       sck,
	input  wire       ssN,
	input  wire       mosi,
	output reg        miso,
	// Test side
	input  wire [7:0] reply,
	output reg  [7:0] got
);
	reg [7:0] shifter;
	initial begin
		miso = 1'h1;
		got = 8'h00;
		shifter = 8'h00;
	end
	// The first bit must be valid before the first sampling edge.
	always @(negedge ssN) begin
		shifter = reply;
		miso = reply[7];
	end
	// Mode 0, MSB first; rotating makes every character return the reply.
	always @(posedge sck) if (!ssN) got <= {got[6:0], mosi};
	always @(negedge sck) if (!ssN) begin
		shifter = {shifter[6:0], shifter[7]};
		miso = shifter[7];
	end
	// A released line must not keep showing the last bit.
	always @(posedge ssN) miso = ~miso;
endmodule // spic_client_model

// >>> verification/spic_core_test.sv
`timescale 1ns/1ps
`include "spic_defines.vh"
module spic_core_test;
	reg         core_clk = 1'h0, arst_n = 1'h1;
	reg         ctrlAWrite = 1'h0, ctrlBWrite = 1'h0, baudWrite = 1'h0;
	reg         addrWrite = 1'h0, dataWrite = 1'h0, dataRead = 1'h0;
	reg         txcClear = 1'h0, ovfClear = 1'h0;
	reg         sckIn = 1'h0, mosiIn = 1'h0, ssIn = 1'h1;
	reg  [31:0] ctrlAData = 32'h0, ctrlBData = 32'h0;
	reg  [7:0]  baudData = 8'h00, addrData = 8'h00, reply = 8'h00;
	reg  [8:0]  dataIn = 9'h000;
	wire [31:0] control_a_register, control_b_register;
	wire [7:0]  baud, matchAddr, got;
	wire [8:0]  receive_holding_register;
	wire [2:0]  sync_busy_register;
	wire        misoIn, txEmptyFlag, txCompleteFlag, rxCompleteFlag;
	wire        bufferOverflow, wakeRequest, sckOut, sckOeN, mosiOut;
	wire        mosiOeN, misoOut, misoOeN, ssOut, ssOeN;
	integer     errors = 0, checks = 0, pass;

	spic_core dut_u (.*);
	spic_client_model peer_u (.sck(sckOut), .ssN(ssOut), .mosi(mosiOut),
		.miso(misoIn), .reply(reply), .got(got));

	always #12.5 core_clk = ~core_clk;

	task complete_run;
		begin
			$display("Comparisons %0d, mismatches %0d", checks, errors);
			if (errors == 0 && checks > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask

	task check(input [31:0] seen, input [31:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("BAD %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask

	// One strobe for one cycle, selected by sel, launched at a falling edge.
	task wr(input [2:0] sel, input [31:0] d);
		begin
			@(negedge core_clk);
			ctrlAData = d;
			ctrlBData = d;
			baudData = d[7:0];
			addrData = d[7:0];
			dataIn = d[8:0];
			ctrlAWrite = (sel == 3'h0);
			ctrlBWrite = (sel == 3'h1);
			baudWrite = (sel == 3'h2);
			addrWrite = (sel == 3'h3);
			dataWrite = (sel == 3'h4);
			dataRead = (sel == 3'h5);
			txcClear = (sel == 3'h6);
			@(negedge core_clk);
			{ctrlAWrite, ctrlBWrite, baudWrite, addrWrite} = 4'h0;
			{dataWrite, dataRead, txcClear} = 3'h0;
		end
	endtask

	// One client bit in mode 0; the half period is two core cycles.
	task cbit(input b);
		begin
			mosiIn = b;
			repeat (2) @(negedge core_clk);
			sckIn = 1'h1;
			repeat (2) @(negedge core_clk);
			sckIn = 1'h0;
		end
	endtask

	// 0: no sync busy, 1: transmit empty, 2: transaction finished.
	task waitfor(input [1:0] what);
		integer n;
		begin
			n = 0;
			while (!((what == 2'h0 && sync_busy_register === 3'h0) ||
				(what == 2'h1 && txEmptyFlag === 1'h1) ||
				(what == 2'h2 && txCompleteFlag === 1'h1 && ssOut === 1'h1))
				&& n < 2000) begin
				@(negedge core_clk);
				n = n + 1;
			end
			if (n >= 2000) begin
				errors = errors + 1;
				$display("BAD %0t wait ran out", $time);
				complete_run;
			end
		end
	endtask

	initial begin
		#1 arst_n = 1'h0;
		repeat (2) @(negedge core_clk);
		arst_n = 1'h1;
		repeat (3) @(negedge core_clk);
		check(control_a_register, `SPIC_CONTROL_A_REGISTER_RST);
		check(txEmptyFlag, 1'h1);
		for (pass = 0; pass < 2; pass = pass + 1) begin
			// Pass 1 turns the bit order round, so both orders are seen.
			wr(3'h0, {1'h0, pass[0], 25'h0, `SPIC_MODE_HOST, 2'h0});
			wr(3'h2, 32'h3);
			wr(3'h3, 32'h5A);
			wr(3'h1, 32'h00022000);
			check(matchAddr, 8'h5A);
			wr(3'h0, control_a_register | 32'h2);
			check(sync_busy_register[1], 1'h1);
			waitfor(2'h0);
			check(control_a_register[1], 1'h1);
			wr(3'h2, 32'h55);
			check(baud, 8'h03);
			reply = pass ? 8'h01 : 8'h3C;
			wr(3'h4, 32'h11);
			waitfor(2'h1);
			wr(3'h4, pass ? 32'h80 : 32'hA5);
			waitfor(2'h2);
			check(got, pass ? 8'h01 : 8'hA5);
			check(rxCompleteFlag, 1'h1);
			repeat (2) begin
				wr(3'h5, 32'h0);
				check(receive_holding_register, pass ? 9'h080 : 9'h03C);
			end
			check(rxCompleteFlag, 1'h0);
			wr(3'h5, 32'h0);
			check(receive_holding_register, pass ? 9'h080 : 9'h03C);
			wr(3'h6, 32'h0);
			check(txCompleteFlag, 1'h0);
			wr(3'h0, control_a_register & ~32'h2);
			waitfor(2'h0);
			check(control_a_register[1], 1'h0);
		end
		wr(3'h0, {27'h0, `SPIC_MODE_CLIENT, 2'h0});
		wr(3'h0, control_a_register | 32'h2);
		waitfor(2'h0);
		check(misoOeN, 1'h1);
		ssIn = 1'h0;
		for (pass = 0; pass < 8; pass = pass + 1)
			cbit(8'hC3 >> (7 - pass));
		check(misoOeN, 1'h0);
		check(rxCompleteFlag, 1'h1);
		ssIn = 1'h1;
		@(negedge core_clk);
		check(wakeRequest, 1'h1);
		check(txCompleteFlag, 1'h1);
		wr(3'h5, 32'h0);
		check(receive_holding_register, 9'h0C3);
		wr(3'h0, 32'h1);
		check(sync_busy_register[0], 1'h1);
		waitfor(2'h0);
		@(negedge core_clk);
		check(control_b_register, `SPIC_CONTROL_B_REGISTER_RST);
		check(baud, `SPIC_BAUD_RST);
		complete_run;
	end
endmodule // spic_core_test
